//--- icc_pkg.sv
// shared constants, register map and types of the configuration command interpreter
package icc_pkg;

  // bus geometry
  localparam int unsigned ADR_W = 8; // byte address bits decoded
  localparam int unsigned DAT_W = 32; // bus data width
  localparam int unsigned SEL_W = 4; // byte lanes

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CMD = 8'h00; // command launch, echo readback
  localparam logic [7:0] OFS_ARG = 8'h04; // command argument
  localparam logic [7:0] OFS_REPLY = 8'h08; // reply value, read pops
  localparam logic [7:0] OFS_STATUS = 8'h0c; // interpreter status
  localparam logic [7:0] OFS_EVT_PROP = 8'h10; // object property 128 view of event_mask
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14; // sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18; // interrupt enables, same layout
  localparam logic [7:0] OFS_IND = 8'h1c; // unsolicited indication, read clears

  // property identifier that carries the event setting
  localparam int unsigned PROP_ID_EVENT = 128;

  // settings widths and defaults
  localparam int unsigned TMO_W = 16; // link_timeout_value width
  localparam int unsigned PORT_W = 16; // link_port_number width
  localparam int unsigned MASK_W = 8; // event_mask width
  localparam logic [TMO_W-1:0] TMO_RST = 16'h03e8; // factory timeout
  localparam logic [MASK_W-1:0] MASK_RST = 8'h00; // factory event setting

  // parameter memory
  localparam int unsigned PAR_DEPTH = 64; // parameter entries
  localparam int unsigned PAR_AW = 6; // parameter index width
  localparam int unsigned PAR_W = 8; // parameter value width
  localparam logic [8:0] PAR_LIMIT = 9'h040; // index plus count ceiling
  localparam logic [PAR_W-1:0] PAR_RST = 8'h00; // blank parameter

  // argument fields
  localparam int unsigned ARG_IDX_LSB = 0; // parameter start index
  localparam int unsigned ARG_CNT_LSB = 8; // parameter count, zero when omitted
  localparam int unsigned ARG_FLD_W = 8; // width of index and count
  localparam logic [ARG_FLD_W-1:0] CNT_DEFAULT = 8'h01; // count taken when omitted

  // event and interrupt bit positions
  localparam int unsigned EV_RESTART = 0; // restart
  localparam int unsigned EV_DONE = 1; // command finished
  localparam int unsigned EV_ERR = 2; // command refused
  localparam int unsigned EV_UPDATE = 3; // global update flag set
  localparam int unsigned EV_CHANGED = 4; // global changed flag set
  localparam int unsigned EV_TIMEOUT = 6; // link timed out

  // status and readback bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_REPLY = 1;
  localparam int unsigned ST_ERR = 2;
  localparam int unsigned ST_IND = 3;
  localparam int unsigned ECHO_VALID = 4; // in command readback
  localparam int unsigned IND_VALID = 8; // in indication readback
  localparam logic [7:0] IND_RESTART_VAL = 8'h01; // restart indication value

  // command codes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_FACTORY = 4'h1,
    OP_PORT_RD = 4'h2,
    OP_TMO_RD = 4'h3,
    OP_TMO_WR = 4'h4,
    OP_PARAM_RD = 4'h5,
    OP_EVT_CFG = 4'h6
  } icc_op_t;

  // interpreter states, gray along idle-exec-erase-restart
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_EXEC = 2'h1,
    S_ERASE = 2'h3,
    S_RESTART = 2'h2
  } icc_state_t;

endpackage

//--- icc_nv_if.sv
// link between the interpreter and its settings store
`timescale 1ns/1ps
interface icc_nv_if;
  logic clear; // factory erase strobe
  logic tmo_we; // timeout write strobe
  logic [icc_pkg::TMO_W-1:0] tmo_wdata; // new timeout
  logic mask_we; // event setting write strobe
  logic [icc_pkg::MASK_W-1:0] mask_wdata; // new event setting
  logic [icc_pkg::PAR_AW-1:0] par_addr; // parameter read index
  logic [icc_pkg::PAR_W-1:0] par_rdata; // parameter value at index
  logic [icc_pkg::TMO_W-1:0] timeout; // stored timeout
  logic [icc_pkg::MASK_W-1:0] mask; // stored event setting

  modport ctl (
    output clear, tmo_we, tmo_wdata, mask_we, mask_wdata, par_addr,
    input par_rdata, timeout, mask
  );
  modport store (
    input clear, tmo_we, tmo_wdata, mask_we, mask_wdata, par_addr,
    output par_rdata, timeout, mask
  );
endinterface

//--- icc_nv_store.sv
// settings store: timeout, event setting and commissioning parameters
`timescale 1ns/1ps
module icc_nv_store (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // interpreter side
  icc_nv_if.store nv,
  // commissioning tool write port
  input wire logic comm_we_i,
  input wire logic [icc_pkg::PAR_AW-1:0] comm_addr_i,
  input wire logic [icc_pkg::PAR_W-1:0] comm_data_i
);

  logic [icc_pkg::TMO_W-1:0] tmo_q, tmo_d; // stored timeout
  logic [icc_pkg::MASK_W-1:0] mask_q, mask_d; // stored event setting
  logic [icc_pkg::PAR_W-1:0] par_q [icc_pkg::PAR_DEPTH]; // parameter image
  logic [icc_pkg::PAR_W-1:0] par_d [icc_pkg::PAR_DEPTH]; // next parameter image

  // scalar settings: erase beats a same-cycle write
  always_comb
  begin
    tmo_d = tmo_q;
    mask_d = mask_q;
    if (nv.clear)
    begin
      tmo_d = icc_pkg::TMO_RST;
      mask_d = icc_pkg::MASK_RST;
    end
    else
    begin
      if (nv.tmo_we)
        tmo_d = nv.tmo_wdata;
      if (nv.mask_we)
        mask_d = nv.mask_wdata;
    end
  end

  // one next-value process per parameter entry
  for (genvar g = 0; g < icc_pkg::PAR_DEPTH; g++)
  begin : g_par
    always_comb
    begin
      par_d[g] = par_q[g];
      if (nv.clear)
        par_d[g] = icc_pkg::PAR_RST;
      else if (comm_we_i && comm_addr_i == icc_pkg::PAR_AW'(g))
        par_d[g] = comm_data_i;
    end
  end

  // registers; power-up image is the factory image
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmo_q <= icc_pkg::TMO_RST;
      mask_q <= icc_pkg::MASK_RST;
      par_q <= '{default: icc_pkg::PAR_RST};
    end
    else
    begin
      tmo_q <= tmo_d;
      mask_q <= mask_d;
      par_q <= par_d;
    end
  end

  // readback toward the interpreter
  assign nv.timeout = tmo_q;
  assign nv.mask = mask_q;
  assign nv.par_rdata = par_q[nv.par_addr];

endmodule

//--- icc_top.sv
// configuration command interpreter with wishbone register access and event interrupt
// Operation
// - factory command erases settings, then restarts
// - port read replies one numeric value
// - timeout read replies current timeout value
// - timeout write stores argument, echoes command
// - parameter read count defaults to one
// - event command stores mask, echoes command
// - mask bits 3,4 raise update/changed events
// - mask bit 6 raises timeout events; bit 0 gates restart events, but reads 0 at every restart
// - event setting read via property 128
// - restart indication $01 is never sent: event setting is $00 at boot and after erase
`timescale 1ns/1ps
module icc_top #(
  parameter logic [icc_pkg::PORT_W-1:0] LINK_PORT = 16'h2ee4 // link_port_number
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [icc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [icc_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [icc_pkg::DAT_W-1:0] wb_dat_i,
  output logic [icc_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // device state inputs
  input wire logic update_flag_i,
  input wire logic changed_flag_i,
  input wire logic link_timeout_i,
  // settings toward the link
  output logic restart_o,
  output logic [icc_pkg::TMO_W-1:0] link_timeout_value_o,
  output logic [icc_pkg::MASK_W-1:0] event_mask_o,
  // commissioning tool parameter port
  input wire logic comm_par_we_i,
  input wire logic [icc_pkg::PAR_AW-1:0] comm_par_addr_i,
  input wire logic [icc_pkg::PAR_W-1:0] comm_par_data_i
);

  // word decode on byte address
  function automatic logic reg_hit(input logic [icc_pkg::ADR_W-1:0] adr, input logic [icc_pkg::ADR_W-1:0] ofs);
    reg_hit = (adr[icc_pkg::ADR_W-1:2] == ofs[icc_pkg::ADR_W-1:2]);
  endfunction

  // byte-lane merge of a write
  function automatic logic [icc_pkg::DAT_W-1:0] wmerge(input logic [icc_pkg::DAT_W-1:0] old,
    input logic [icc_pkg::DAT_W-1:0] wd, input logic [icc_pkg::SEL_W-1:0] sel);
    logic [icc_pkg::DAT_W-1:0] r;
    r = old;
    for (int b = 0; b < icc_pkg::SEL_W; b++)
      if (sel[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    wmerge = r;
  endfunction

  icc_nv_if nv (); // settings store link

  // bus state
  logic ack_q, ack_d; // one-cycle acknowledge
  logic [icc_pkg::DAT_W-1:0] dat_q, dat_d; // registered read data
  // command state
  icc_pkg::icc_state_t st_q, st_d; // interpreter state
  icc_pkg::icc_op_t op_q, op_d; // command under work, echoed
  logic echo_v_q, echo_v_d; // echo available
  logic [icc_pkg::DAT_W-1:0] arg_q, arg_d; // argument register
  logic [icc_pkg::TMO_W-1:0] reply_q, reply_d; // single-value reply
  logic rep_par_q, rep_par_d; // reply comes from parameter memory
  logic [icc_pkg::ARG_FLD_W-1:0] remain_q, remain_d; // reply values left
  logic [icc_pkg::PAR_AW-1:0] idx_q, idx_d; // next parameter index
  logic err_q, err_d; // last command refused
  logic restart_q, restart_d; // restart strobe
  logic boot_q, boot_d; // first cycle after reset
  // event state
  logic upd_q, upd_d; // previous update flag
  logic chg_q, chg_d; // previous changed flag
  logic [icc_pkg::MASK_W-1:0] irq_st_q, irq_st_d; // sticky events
  logic [icc_pkg::MASK_W-1:0] irq_msk_q, irq_msk_d; // interrupt enables
  logic ind_v_q, ind_v_d; // indication pending
  // combinational strobes
  logic acc, wr, rd; // bus access qualifiers
  logic done_ev, err_ev, restart_ev; // command events
  logic [icc_pkg::MASK_W-1:0] ev; // event vector, status layout
  logic [icc_pkg::ARG_FLD_W-1:0] a_idx, a_cnt, cnt_eff; // parameter argument fields
  logic par_ok; // parameter range fits

  // store holds the non-volatile settings
  icc_nv_store u_store (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .nv (nv.store),
    .comm_we_i (comm_par_we_i),
    .comm_addr_i (comm_par_addr_i),
    .comm_data_i (comm_par_data_i)
  );

  // access qualifiers: one access per request, answered next cycle
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;

  // parameter argument, omitted count means one
  assign a_idx = arg_q[icc_pkg::ARG_IDX_LSB +: icc_pkg::ARG_FLD_W];
  assign a_cnt = arg_q[icc_pkg::ARG_CNT_LSB +: icc_pkg::ARG_FLD_W];
  assign cnt_eff = (a_cnt == '0) ? icc_pkg::CNT_DEFAULT : a_cnt;
  assign par_ok = ({1'b0, a_idx} + {1'b0, cnt_eff}) <= icc_pkg::PAR_LIMIT;

  // interpreter next state
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    echo_v_d = echo_v_q;
    arg_d = arg_q;
    reply_d = reply_q;
    rep_par_d = rep_par_q;
    remain_d = remain_q;
    idx_d = idx_q;
    err_d = err_q;
    restart_d = 1'b0;
    boot_d = 1'b0;
    done_ev = 1'b0;
    err_ev = 1'b0;
    restart_ev = boot_q;
    nv.clear = 1'b0;
    nv.tmo_we = 1'b0;
    nv.mask_we = 1'b0;
    nv.tmo_wdata = arg_q[icc_pkg::TMO_W-1:0];
    nv.mask_wdata = arg_q[icc_pkg::MASK_W-1:0];
    // argument write
    if (wr && reg_hit(wb_adr_i, icc_pkg::OFS_ARG))
      arg_d = wmerge(arg_q, wb_dat_i, wb_sel_i);
    // reply pop walks upward through the parameters
    if (rd && reg_hit(wb_adr_i, icc_pkg::OFS_REPLY) && remain_q != '0)
    begin
      remain_d = remain_q - 1'b1;
      idx_d = idx_q + 1'b1;
    end
    unique case (st_q)
      icc_pkg::S_IDLE:
      begin
        if (wr && reg_hit(wb_adr_i, icc_pkg::OFS_CMD) && wb_sel_i[0])
        begin
          op_d = icc_pkg::icc_op_t'(wb_dat_i[3:0]);
          echo_v_d = 1'b0;
          remain_d = '0;
          st_d = icc_pkg::S_EXEC;
        end
      end
      icc_pkg::S_EXEC:
      begin
        st_d = icc_pkg::S_IDLE;
        err_d = 1'b0;
        done_ev = 1'b1;
        case (op_q)
          icc_pkg::OP_FACTORY:
          begin
            st_d = icc_pkg::S_ERASE;
            done_ev = 1'b0;
          end
          icc_pkg::OP_PORT_RD:
          begin
            reply_d = LINK_PORT;
            rep_par_d = 1'b0;
            remain_d = icc_pkg::CNT_DEFAULT;
          end
          icc_pkg::OP_TMO_RD:
          begin
            reply_d = nv.timeout;
            rep_par_d = 1'b0;
            remain_d = icc_pkg::CNT_DEFAULT;
          end
          icc_pkg::OP_TMO_WR:
          begin
            nv.tmo_we = 1'b1;
            echo_v_d = 1'b1;
          end
          icc_pkg::OP_PARAM_RD:
          begin
            if (par_ok)
            begin
              idx_d = a_idx[icc_pkg::PAR_AW-1:0];
              remain_d = cnt_eff;
              rep_par_d = 1'b1;
            end
            else
            begin
              err_d = 1'b1;
              err_ev = 1'b1;
              done_ev = 1'b0;
            end
          end
          icc_pkg::OP_EVT_CFG:
          begin
            nv.mask_we = 1'b1;
            echo_v_d = 1'b1;
          end
          // no code writes parameters; unknown codes are refused
          default:
          begin
            err_d = 1'b1;
            err_ev = 1'b1;
            done_ev = 1'b0;
          end
        endcase
      end
      icc_pkg::S_ERASE:
      begin
        nv.clear = 1'b1;
        st_d = icc_pkg::S_RESTART;
      end
      icc_pkg::S_RESTART:
      begin
        // restart of the command context: command, echo, argument, count and error cleared; reply value and index kept
        restart_d = 1'b1;
        restart_ev = 1'b1;
        done_ev = 1'b1;
        op_d = icc_pkg::OP_NONE;
        echo_v_d = 1'b0;
        arg_d = '0;
        remain_d = '0;
        err_d = 1'b0;
        st_d = icc_pkg::S_IDLE;
      end
    endcase
    // a launch while busy is refused; after the case so the error outlasts a finishing clear
    if (wr && reg_hit(wb_adr_i, icc_pkg::OFS_CMD) && wb_sel_i[0] && st_q != icc_pkg::S_IDLE)
    begin
      err_d = 1'b1;
      err_ev = 1'b1;
    end
  end

  // interpreter registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= icc_pkg::S_IDLE;
      op_q <= icc_pkg::OP_NONE;
      echo_v_q <= 1'b0;
      arg_q <= '0;
      reply_q <= '0;
      rep_par_q <= 1'b0;
      remain_q <= '0;
      idx_q <= '0;
      err_q <= 1'b0;
      restart_q <= 1'b0;
      boot_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      echo_v_q <= echo_v_d;
      arg_q <= arg_d;
      reply_q <= reply_d;
      rep_par_q <= rep_par_d;
      remain_q <= remain_d;
      idx_q <= idx_d;
      err_q <= err_d;
      restart_q <= restart_d;
      boot_q <= boot_d;
    end
  end

  // event next state: new events win over a same-cycle clear
  always_comb
  begin
    ev = '0;
    ev[icc_pkg::EV_RESTART] = restart_ev && nv.mask[icc_pkg::EV_RESTART];
    ev[icc_pkg::EV_UPDATE] = update_flag_i && !upd_q && nv.mask[icc_pkg::EV_UPDATE];
    ev[icc_pkg::EV_CHANGED] = changed_flag_i && !chg_q && nv.mask[icc_pkg::EV_CHANGED];
    ev[icc_pkg::EV_TIMEOUT] = link_timeout_i && nv.mask[icc_pkg::EV_TIMEOUT];
    ev[icc_pkg::EV_DONE] = done_ev;
    ev[icc_pkg::EV_ERR] = err_ev;
    upd_d = update_flag_i;
    chg_d = changed_flag_i;
    irq_st_d = irq_st_q;
    irq_msk_d = irq_msk_q;
    ind_v_d = ind_v_q;
    if (wr && reg_hit(wb_adr_i, icc_pkg::OFS_IRQ_STAT) && wb_sel_i[0])
      irq_st_d = irq_st_q & ~wb_dat_i[icc_pkg::MASK_W-1:0];
    irq_st_d = irq_st_d | ev;
    if (wr && reg_hit(wb_adr_i, icc_pkg::OFS_IRQ_MASK) && wb_sel_i[0])
      irq_msk_d = wb_dat_i[icc_pkg::MASK_W-1:0];
    if (rd && reg_hit(wb_adr_i, icc_pkg::OFS_IND))
      ind_v_d = 1'b0;
    if (ev[icc_pkg::EV_RESTART])
      ind_v_d = 1'b1;
  end

  // event registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upd_q <= 1'b0;
      chg_q <= 1'b0;
      irq_st_q <= '0;
      irq_msk_q <= '0;
      ind_v_q <= 1'b0;
    end
    else
    begin
      upd_q <= upd_d;
      chg_q <= chg_d;
      irq_st_q <= irq_st_d;
      irq_msk_q <= irq_msk_d;
      ind_v_q <= ind_v_d;
    end
  end

  // bus next state: read mux, unmapped words read zero
  always_comb
  begin
    ack_d = acc;
    dat_d = dat_q;
    if (rd)
    begin
      dat_d = '0;
      if (reg_hit(wb_adr_i, icc_pkg::OFS_CMD))
        dat_d = 32'({echo_v_q, op_q});
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_ARG))
        dat_d = arg_q;
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_REPLY) && remain_q != '0)
        dat_d = rep_par_q ? 32'(nv.par_rdata) : 32'(reply_q);
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_STATUS))
        dat_d = 32'({ind_v_q, err_q, remain_q != '0, st_q != icc_pkg::S_IDLE});
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_EVT_PROP))
        dat_d = 32'(nv.mask);
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_IRQ_STAT))
        dat_d = 32'(irq_st_q);
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_IRQ_MASK))
        dat_d = 32'(irq_msk_q);
      else if (reg_hit(wb_adr_i, icc_pkg::OFS_IND))
        dat_d = 32'({ind_v_q, ind_v_q ? icc_pkg::IND_RESTART_VAL : 8'h00});
    end
  end

  // bus registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // outputs
  assign nv.par_addr = idx_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o = |(irq_st_q & irq_msk_q);
  assign restart_o = restart_q;
  assign link_timeout_value_o = nv.timeout;
  assign event_mask_o = nv.mask;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_factory_seq: assert property ((st_q == icc_pkg::S_EXEC && op_q == icc_pkg::OP_FACTORY)
    |=> nv.clear ##2 restart_o ##1 (nv.timeout == icc_pkg::TMO_RST && nv.mask == icc_pkg::MASK_RST))
    else $error("factory erase and restart out of order");
  a_port_reply: assert property ((st_q == icc_pkg::S_EXEC && op_q == icc_pkg::OP_PORT_RD)
    |=> (reply_q == LINK_PORT && remain_q == icc_pkg::CNT_DEFAULT && !rep_par_q))
    else $error("port reply wrong");
  a_tmo_reply: assert property ((st_q == icc_pkg::S_EXEC && op_q == icc_pkg::OP_TMO_RD)
    |=> (reply_q == $past(nv.timeout) && remain_q == icc_pkg::CNT_DEFAULT))
    else $error("timeout reply wrong");
  a_tmo_store: assert property ((st_q == icc_pkg::S_EXEC && op_q == icc_pkg::OP_TMO_WR)
    |=> (nv.timeout == $past(arg_q[icc_pkg::TMO_W-1:0]) && echo_v_q))
    else $error("timeout not stored or echoed");
  a_count_default: assert property ((st_q == icc_pkg::S_EXEC && op_q == icc_pkg::OP_PARAM_RD && a_cnt == '0 && par_ok)
    |=> (remain_q == icc_pkg::CNT_DEFAULT && rep_par_q))
    else $error("omitted count not one");
  a_param_order: assert property ((rd && reg_hit(wb_adr_i, icc_pkg::OFS_REPLY) && remain_q != '0 && rep_par_q)
    |=> (idx_q == $past(idx_q) + 1'b1 && wb_dat_o == 32'($past(nv.par_rdata))))
    else $error("parameter reply out of order");
  a_mask_store: assert property ((st_q == icc_pkg::S_EXEC && op_q == icc_pkg::OP_EVT_CFG)
    |=> (nv.mask == $past(arg_q[icc_pkg::MASK_W-1:0]) && echo_v_q))
    else $error("event mask not stored or echoed");
  a_update_event: assert property (($rose(update_flag_i) && nv.mask[icc_pkg::EV_UPDATE])
    |=> irq_st_q[icc_pkg::EV_UPDATE])
    else $error("update event lost");
  a_timeout_event: assert property ((link_timeout_i && nv.mask[icc_pkg::EV_TIMEOUT])
    |=> irq_st_q[icc_pkg::EV_TIMEOUT])
    else $error("timeout event lost");
  a_prop_view: assert property ((rd && reg_hit(wb_adr_i, icc_pkg::OFS_EVT_PROP))
    |=> wb_dat_o == 32'($past(nv.mask)))
    else $error("property view differs from mask");
  a_restart_ind: assert property ((restart_ev && nv.mask[icc_pkg::EV_RESTART])
    |=> (ind_v_q && irq_st_q[icc_pkg::EV_RESTART]))
    else $error("restart indication missing");

  c_factory: cover property (st_q == icc_pkg::S_ERASE ##2 restart_o);
  c_param_multi: cover property (rep_par_q && remain_q == 8'h04);
  c_irq: cover property (irq_o && irq_st_q[icc_pkg::EV_CHANGED]);

endmodule

//--- icc_host_model.sv
// host controller model: classic wishbone master issuing configuration commands
`timescale 1ns/1ps
module icc_host_model (
  // clock
  input wire logic clk_i,
  // wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // idle bus at time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // one access; entered right after a rising edge, holds until ack is sampled
  // settings-writing commands are issued only by explicit scenarios, never looped
  // parameters are only read through this port, never written
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hf;
    wb_dat_o <= wd;
    // no cycle count assumed: only the bench's hang guard ends this wait
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

//--- tb.sv
// self-checking testbench of the configuration command interpreter
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, irq, rst_pulse;
  logic [7:0] adr, mask_o;
  logic [3:0] sel;
  logic [31:0] wd, rdat;
  logic [2:0] ev = 3'h0; // link timeout, changed, update
  logic par_we = 1'b0;
  logic [5:0] par_a = 6'h0;
  logic [7:0] par_d = 8'h0;
  logic [15:0] tmo_o;
  int n_errors = 0, num_checks = 0, n_restart = 0, cyc_cnt = 0;
  // 125 MHz clock
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  icc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .update_flag_i(ev[0]),
    .changed_flag_i(ev[1]), .link_timeout_i(ev[2]), .restart_o(rst_pulse), .link_timeout_value_o(tmo_o),
    .event_mask_o(mask_o), .comm_par_we_i(par_we), .comm_par_addr_i(par_a), .comm_par_data_i(par_d));
  icc_host_model i_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wd), .wb_dat_i(rdat), .wb_ack_i(ack));
  // restart pulse counter and hang guard
  always @(posedge clk_i)
  begin
    n_restart <= n_restart + int'(rst_pulse === 1'b1);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  // compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_host.xfer(1'b1, a, d, x);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    i_host.xfer(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask
  // launch a command and wait for busy to clear
  task cmd(input logic [3:0] op, input logic [31:0] arg);
    logic [31:0] s;
    int n;
    wr(icc_pkg::OFS_ARG, arg);
    wr(icc_pkg::OFS_CMD, {28'h0, op});
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 20)
    begin
      i_host.xfer(1'b0, icc_pkg::OFS_STATUS, 32'h0, s);
      n++;
    end
    chk("busy", {31'h0, s[0]}, 32'h0);
  endtask
  // port, timeout read and write
  task t_link;
    cmd(4'h2, 32'h0);
    rdc("st reply", icc_pkg::OFS_STATUS, 32'h2);
    rdc("port", icc_pkg::OFS_REPLY, 32'h2ee4);
    rdc("port end", icc_pkg::OFS_REPLY, 32'h0);
    cmd(4'h4, 32'h2ee0);
    rdc("echo tmo", icc_pkg::OFS_CMD, 32'h14);
    chk("tmo out", {16'h0, tmo_o}, 32'h2ee0);
    cmd(4'h3, 32'h0);
    rdc("tmo rd", icc_pkg::OFS_REPLY, 32'h2ee0);
  endtask
  // parameters written by commissioning port, read ascending
  task t_param;
    for (int i = 0; i < 4; i++)
    begin
      par_we <= 1'b1;
      par_a <= 6'(10 + i);
      par_d <= 8'(i + 1);
      @(posedge clk_i);
    end
    par_we <= 1'b0;
    @(posedge clk_i);
    cmd(4'h5, 32'h040a);
    for (int i = 0; i < 5; i++)
      rdc("par", icc_pkg::OFS_REPLY, (i < 4) ? 32'(i + 1) : 32'h0);
    cmd(4'h5, 32'h000b);
    rdc("par one", icc_pkg::OFS_REPLY, 32'h2);
    rdc("par one end", icc_pkg::OFS_REPLY, 32'h0);
  endtask
  // event mask setting and event interrupts
  task t_event;
    wr(icc_pkg::OFS_IRQ_MASK, 32'h58);
    cmd(4'h6, 32'h59);
    rdc("echo evt", icc_pkg::OFS_CMD, 32'h16);
    chk("mask out", {24'h0, mask_o}, 32'h59);
    rdc("prop", icc_pkg::OFS_EVT_PROP, 32'h59);
    for (int i = 0; i < 3; i++)
    begin
      wr(icc_pkg::OFS_IRQ_STAT, 32'hff);
      chk("irq low", {31'h0, irq}, 32'h0);
      ev <= 3'(1 << i);
      @(posedge clk_i);
      ev <= 3'h0;
      @(posedge clk_i);
      rdc("ev stat", icc_pkg::OFS_IRQ_STAT, (i == 2) ? 32'h40 : 32'(8 << i));
      chk("irq high", {31'h0, irq}, 32'h1);
    end
    cmd(4'h6, 32'h0);
    wr(icc_pkg::OFS_IRQ_STAT, 32'hff);
    ev <= 3'h1;
    @(posedge clk_i);
    ev <= 3'h0;
    @(posedge clk_i);
    rdc("ev off", icc_pkg::OFS_IRQ_STAT, 32'h0);
  endtask
  // factory erase and restart
  task t_factory;
    cmd(4'h6, 32'h59);
    cmd(4'h1, 32'h0);
    chk("restarts", 32'(n_restart), 32'h1);
    chk("tmo rst", {16'h0, tmo_o}, 32'h03e8);
    rdc("prop rst", icc_pkg::OFS_EVT_PROP, 32'h0);
    cmd(4'h5, 32'h000a);
    rdc("par rst", icc_pkg::OFS_REPLY, 32'h0);
  endtask
  // refused commands: unknown code, range overrun, launch while restarting
  task t_error;
    cmd(4'h7, 32'h0);
    rdc("bad op", icc_pkg::OFS_STATUS, 32'h4);
    cmd(4'h5, 32'h0240);
    rdc("par range", icc_pkg::OFS_STATUS, 32'h4);
    wr(icc_pkg::OFS_IRQ_STAT, 32'hff);
    wr(icc_pkg::OFS_CMD, 32'h1);
    wr(icc_pkg::OFS_CMD, 32'h2);
    rdc("busy refuse", icc_pkg::OFS_STATUS, 32'h4);
    rdc("err ev", icc_pkg::OFS_IRQ_STAT, 32'h6);
    rdc("ind none", icc_pkg::OFS_IND, 32'h0);
  endtask
  // verdict and end of run
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("tmo init", {16'h0, tmo_o}, 32'h03e8);
    t_link();
    t_param();
    t_event();
    t_factory();
    t_error();
    summarize();
  end
endmodule
